// ---- bench/serial_keyboard_receiver_bench.sv ----
// Self-checking bench for the serial keyboard receiver.
module serial_keyboard_receiver_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Stimulus, tasks and checks
  // ****************************************************************
  logic        clk, rstn, ser, p1, p2, awv, wv, bre, arv, rre, snd, gli, bsy;
  logic [17:0] ins;
  logic [7:0]  awa, ara, ch;
  logic [2:0]  cv;
  logic [31:0] wd;
  wire logic   oe_n, rq, irq, pint, ira, adv, prl, awr, wr, bv, arr, rv, txi, sko;
  wire logic [17:0] iod;
  wire logic [31:0] rdo;
  wire logic [1:0]  bresp, rresp;
  int          mismatches, n_tests, seed;
  bit          saw;
  skr_receiver #(.FIRST_DELAY_CYC(20'hc8), .UNIT_CYC(20'h190)) dut (
    .clk_sys_in(clk), .resetn_in(rstn), .serial_line_in(ser), .io_instr_in(ins),
    .io_pulse_first_in(p1), .io_pulse_second_in(p2), .skip_line_in(oe_n),
    .skip_line_out(sko), .skip_line_oe_n_out(oe_n), .read_request_out(rq), .io_data_out(iod),
    .interrupt_request_out(ira), .prog_interrupt_out(pint), .reader_advance_out(adv),
    .printer_release_out(prl), .tx_clock_inhibit_out(txi), .irq_out(irq),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdo), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rre));
  skr_term_model term (.clk_in(clk), .send_in(snd), .glitch_in(gli), .data_in(ch),
    .line_out(ser), .busy_out(bsy));
  // The character lands first unit in the low bit, in bus positions zero to seven.
  function automatic logic [31:0] bus_word(input logic [7:0] c);
    return {24'h0, c};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Write and read hold each channel until its ready is sampled high.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awa, wd, awv, wv, bre} <= {a, d, 3'h7};
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
    chk(bresp, 0);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    {ara, arv, rre} <= {a, 2'h3};
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rre <= 1'b0;
    chk(rdo, e);
    chk(rresp, er);
  endtask
  // One instruction with one pulse; the skip line is watched for four cycles.
  task automatic iop(input logic [17:0] i, input logic second);
    @(posedge clk);
    {ins, p1, p2} <= {i, !second, second};
    @(posedge clk);
    {p1, p2} <= 2'h0;
    saw = 0;
    repeat (4) begin
      @(posedge clk);
      saw |= !oe_n;
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // A hung handshake or frame still reaches the verdict.
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    seed = 51939;
    {rstn, p1, p2, awv, wv, bre, arv, rre, snd, gli, ins, awa, ara, ch, wd} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    axr(skr_pkg::OFF_CTRL, 0, skr_pkg::RESP_OKAY);
    axr(8'h1c, 0, skr_pkg::RESP_SLVERR);
    axw(skr_pkg::OFF_CTRL, 32'h7);
    axw(skr_pkg::OFF_IRQ_MASK, 32'h3);
    iop(18'h380d2, 1'b1);
    chk(adv, 1);
    for (int k = 0; k < 5; k++) begin
      // The first two characters run with echo, duplex and interrupt enable all set; each later one clears one of them.
      cv = (k == 2) ? 3'h3 : (k == 3) ? 3'h5 : (k == 4) ? 3'h6 : 3'h7;
      axw(skr_pkg::OFF_CTRL, {29'h0, cv});
      ch <= (k == 1) ? 8'hff : (k == 2) ? 8'h00 : 8'($random(seed));
      snd <= 1'b1;
      @(posedge clk);
      snd <= 1'b0;
      repeat (5) @(posedge clk);
      chk(prl, cv[skr_pkg::CTRL_ECHO]);
      while (ira !== 1'b1) @(posedge clk);
      chk(adv, 0);
      chk(pint, cv[skr_pkg::CTRL_IE]);
      chk(txi, !cv[skr_pkg::CTRL_DUPLEX]);
      iop(18'h38101, 1'b0);
      chk(saw, 0);
      iop(18'h380c1, 1'b0);
      chk(saw, 1);
      chk(sko, 0);
      chk(irq, 1);
      iop(18'h380ca, 1'b1);
      chk(rq, 1);
      chk(iod, bus_word(ch));
      chk(ira, 0);
      ins <= '0;
      axr(skr_pkg::OFF_IRQ_STAT, 1, skr_pkg::RESP_OKAY);
      axr(skr_pkg::OFF_IRQ_STAT, 0, skr_pkg::RESP_OKAY);
      axr(skr_pkg::OFF_DATA, bus_word(ch), skr_pkg::RESP_OKAY);
      chk(irq, 0);
      while (bsy !== 1'b0) @(posedge clk);
      // Reception over: only the last-unit flag and the idle skip line remain.
      axr(skr_pkg::OFF_STATUS, 32'h24, skr_pkg::RESP_OKAY);
    end
    gli <= 1'b1;
    @(posedge clk);
    gli <= 1'b0;
    repeat (600) @(posedge clk);
    axr(skr_pkg::OFF_IRQ_STAT, 2, skr_pkg::RESP_OKAY);
    chk(ira, 0);
    tally_and_finish;
  end
endmodule // serial_keyboard_receiver_bench

// ---- bench/skr_term_model.sv ----
// Terminal model that sends framed characters on the receive line.
module skr_term_model (
  input  wire logic       clk_in,
  input  wire logic       send_in,
  input  wire logic       glitch_in,
  input  wire logic [7:0] data_in,
  output logic            line_out,
  output logic            busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Frame generator
  // ****************************************************************
  logic [10:0] frame;
  bit          g;
  // The line idles at mark between frames.
  initial begin
    line_out = 1'b1;
    busy_out = 1'b0;
  end
  // A glitch is one short space that outlasts a processor tick but not a half unit.
  always @(posedge clk_in) begin
    frame = {2'h3, data_in, 1'h0};
    if (send_in || glitch_in) begin
      g = glitch_in;
      busy_out <= 1'b1;
      for (int i = 0; i < (g ? 1 : 11); i++) begin
        line_out <= frame[i];
        repeat (g ? 160 : 400) @(posedge clk_in);
      end
      line_out <= 1'b1;
      busy_out <= 1'b0;
    end
  end
endmodule // skr_term_model

// ---- core/skr_bit_clock.sv ----
// Receive bit clock: half-unit first delay, then one tick per code unit.
module skr_bit_clock #(
  parameter logic [skr_pkg::CNT_W-1:0] FIRST_DELAY_CYC = skr_pkg::FIRST_DELAY_CNT,
  parameter logic [skr_pkg::CNT_W-1:0] UNIT_CYC        = skr_pkg::UNIT_CNT
) (
  input  wire logic   clk_sys_in,
  input  wire logic   resetn_in,
  skr_bitclk_if.gen   bus
);

  logic                      running_q;
  logic [skr_pkg::CNT_W-1:0] cnt_q;
  logic                      tick_q;

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Dropping run stops the count at once, so no stale tick follows.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      running_q <= 1'b0;
      cnt_q     <= '0;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (!bus.run) begin
        running_q <= 1'b0;
      end else if (!running_q) begin
        running_q <= 1'b1;
        cnt_q     <= FIRST_DELAY_CYC - 1'b1;
      end else if (cnt_q == '0) begin
        tick_q <= 1'b1;
        cnt_q  <= UNIT_CYC - 1'b1;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign bus.tick = tick_q;

endmodule // skr_bit_clock

// ---- core/skr_io_decode.sv ----
// Device select and instruction pulse decode for the receiver.
module skr_io_decode (
  input  wire logic [17:0] instr_in,
  input  wire logic        io_pulse_first_in,
  input  wire logic        io_pulse_second_in,
  output logic             device_select_out,
  output logic             skip_cmd_out,
  output logic             read_cmd_out,
  output logic             step_cmd_out
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Select needs both the transfer opcode and this device code.
  always_comb begin
    device_select_out =
      (instr_in[skr_pkg::OPC_HI:skr_pkg::OPC_LO] == skr_pkg::IOT_OPCODE) &&
      (instr_in[skr_pkg::SEL_HI:skr_pkg::SEL_LO] == skr_pkg::DEV_CODE);
    skip_cmd_out = device_select_out && io_pulse_first_in &&
                   instr_in[skr_pkg::BIT_MB17];
    read_cmd_out = device_select_out && io_pulse_second_in &&
                   instr_in[skr_pkg::BIT_MB16];
    step_cmd_out = read_cmd_out && instr_in[skr_pkg::BIT_MB13];
  end

endmodule // skr_io_decode

// ---- core/skr_receiver.sv ----
// Serial keyboard and tape reader receiver with I/O bus and register port.
//
// Summary of operation
// - Assemble character in 8-bit register, mark=1.
// - Start space sets active on processor tick.
// - Activation initialises register, starts receive clock.
// - Bit clock: half-unit delay, then unit rate.
// - Shift pulse only while last-unit clear.
// - Every shift pulse stops reader advance; a reader step in the same cycle wins and sets it.
// - Shift loads serial level into MSB.
// - Ninth shift sets character and last flags.
// - Tick after last unit ends reception.
// - Mark at first tick rejects false start.
// - Character flag raises program interrupt request.
// - Start space releases printer for local echo.
// - Reader step sets reader advance.
// - Skip instruction pulls skip line on flag.
// - Read instruction clears flag, sets read latch.
// - Read latch places character on bus.
// - Respond only when instruction selects device.
// - Full duplex keeps transmit clock running.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
module skr_receiver #(
  parameter logic [skr_pkg::CNT_W-1:0] FIRST_DELAY_CYC = skr_pkg::FIRST_DELAY_CNT,
  parameter logic [skr_pkg::CNT_W-1:0] UNIT_CYC        = skr_pkg::UNIT_CNT
) (
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic        serial_line_in,
  input  wire logic [17:0] io_instr_in,
  input  wire logic        io_pulse_first_in,
  input  wire logic        io_pulse_second_in,
  input  wire logic        skip_line_in,
  output logic             skip_line_out,
  output logic             skip_line_oe_n_out,
  output logic             read_request_out,
  output logic [17:0]      io_data_out,
  output logic             interrupt_request_out,
  output logic             prog_interrupt_out,
  output logic             reader_advance_out,
  output logic             printer_release_out,
  output logic             tx_clock_inhibit_out,
  output logic             irq_out,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [skr_pkg::CPU_CNT_W-1:0] cpu_cnt_q;
  logic                          cpu_tick;
  logic                          rx_active_q;
  logic                          last_unit_q;
  logic                          char_ready_flag_q;
  logic                          reader_advance_q;
  logic                          read_latch_q;
  logic [7:0]                    rx_shift_reg_q;
  logic                          rx_init_pulse;
  logic                          rx_bit_clock;
  logic                          rx_shift_pulse;
  logic                          reg_all_ones;
  logic                          false_start;
  logic                          last_shift;
  logic                          device_select;
  logic                          skip_cmd;
  logic                          read_cmd;
  logic                          step_cmd;
  logic [skr_pkg::CTRL_W-1:0]    ctrl_q;
  logic [skr_pkg::IRQ_W-1:0]     irq_stat_q;
  logic [skr_pkg::IRQ_W-1:0]     irq_mask_q;
  logic [skr_pkg::IRQ_W-1:0]     irq_clr;
  logic [7:0]                    aw_addr_q;
  logic [31:0]                   w_data_q;
  logic                          w_lane0_q;
  logic                          wr_en;
  logic                          rd_en;

  skr_bitclk_if bclk_if ();

  // ****************************************************************
  // Submodules
  // ****************************************************************
  skr_bit_clock #(
    .FIRST_DELAY_CYC (FIRST_DELAY_CYC),
    .UNIT_CYC        (UNIT_CYC)
  ) u_bit_clock (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .bus        (bclk_if.gen)
  );

  skr_io_decode u_io_decode (
    .instr_in           (io_instr_in),
    .io_pulse_first_in  (io_pulse_first_in),
    .io_pulse_second_in (io_pulse_second_in),
    .device_select_out  (device_select),
    .skip_cmd_out       (skip_cmd),
    .read_cmd_out       (read_cmd),
    .step_cmd_out       (step_cmd)
  );

  // ****************************************************************
  // Processor clock pulse
  // ****************************************************************
  // Free-running strobe that samples the line for a start space.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      cpu_cnt_q <= '0;
    end else if (cpu_cnt_q == skr_pkg::CPU_TICK_LAST) begin
      cpu_cnt_q <= '0;
    end else begin
      cpu_cnt_q <= cpu_cnt_q + 1'b1;
    end
  end

  assign cpu_tick = (cpu_cnt_q == skr_pkg::CPU_TICK_LAST);

  // ****************************************************************
  // Receive sequencing terms
  // ****************************************************************
  // A space seen on a processor tick starts a character.
  assign rx_init_pulse  = cpu_tick && !serial_line_in && !rx_active_q;
  assign rx_bit_clock   = bclk_if.tick;
  assign bclk_if.run    = rx_active_q;
  assign reg_all_ones   = (rx_shift_reg_q == skr_pkg::SHIFT_INIT);
  // Mark returned while still all ones means the space was noise.
  assign false_start    = rx_bit_clock && rx_active_q && !last_unit_q &&
                          serial_line_in && reg_all_ones;
  assign rx_shift_pulse = rx_bit_clock && rx_active_q && !last_unit_q &&
                          !false_start;
  // The start space sitting in the low bit marks the ninth shift.
  assign last_shift     = rx_shift_pulse && !rx_shift_reg_q[0];

  // Receive-active flip-flop.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rx_active_q <= 1'b0;
    end else if (rx_init_pulse) begin
      rx_active_q <= 1'b1;
    end else if (rx_bit_clock && (last_unit_q || false_start)) begin
      rx_active_q <= 1'b0;
    end
  end

  // Shift register; a space is 0 and a mark is 1.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rx_shift_reg_q <= skr_pkg::SHIFT_INIT;
    end else if (rx_init_pulse) begin
      rx_shift_reg_q <= skr_pkg::SHIFT_INIT;
    end else if (rx_shift_pulse) begin
      rx_shift_reg_q <= {serial_line_in, rx_shift_reg_q[7:1]};
    end
  end

  // Last-unit flag.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      last_unit_q <= 1'b0;
    end else if (rx_init_pulse) begin
      last_unit_q <= 1'b0;
    end else if (last_shift) begin
      last_unit_q <= 1'b1;
    end
  end

  // Character flag; a new character wins over a read in the same cycle.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      char_ready_flag_q <= 1'b0;
    end else if (last_shift) begin
      char_ready_flag_q <= 1'b1;
    end else if (read_cmd) begin
      char_ready_flag_q <= 1'b0;
    end
  end

  // Reader advance; holding it past one shift would feed a second line.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      reader_advance_q <= 1'b0;
    end else if (step_cmd) begin
      reader_advance_q <= 1'b1;
    end else if (rx_shift_pulse) begin
      reader_advance_q <= 1'b0;
    end
  end

  // Read latch holds until the instruction no longer selects us.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      read_latch_q <= 1'b0;
    end else if (read_cmd) begin
      read_latch_q <= 1'b1;
    end else if (!device_select) begin
      read_latch_q <= 1'b0;
    end
  end

  // ****************************************************************
  // I/O bus and terminal outputs
  // ****************************************************************
  // Every pin is registered, so each shows its cause one cycle later.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      read_request_out      <= 1'b0;
      io_data_out           <= '0;
      skip_line_out         <= 1'b0;
      skip_line_oe_n_out    <= 1'b1;
      interrupt_request_out <= 1'b0;
      prog_interrupt_out    <= 1'b0;
      printer_release_out   <= 1'b0;
      tx_clock_inhibit_out  <= 1'b0;
    end else begin
      read_request_out <= read_latch_q;
      io_data_out <= read_latch_q ? {10'h000, rx_shift_reg_q} : '0;
      skip_line_out <= 1'b0;
      skip_line_oe_n_out <= !(skip_cmd && char_ready_flag_q);
      interrupt_request_out <= char_ready_flag_q;
      prog_interrupt_out <= char_ready_flag_q && ctrl_q[skr_pkg::CTRL_IE];
      printer_release_out <= !serial_line_in && !char_ready_flag_q &&
                             ctrl_q[skr_pkg::CTRL_ECHO];
      // In full duplex the transmit clock keeps running during receive.
      tx_clock_inhibit_out <= rx_active_q &&
                              !ctrl_q[skr_pkg::CTRL_DUPLEX];
    end
  end

  assign reader_advance_out = reader_advance_q;

  // ****************************************************************
  // Register bus: write channel
  // ****************************************************************
  // Address and data are taken in either order; one write at a time.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= skr_pkg::RESP_OKAY;
      aw_addr_q         <= '0;
      w_data_q          <= '0;
      w_lane0_q         <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr_q         <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data_q         <= s_axi_wdata_in;
        w_lane0_q        <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'b0;
      end
      if (wr_en) begin
        s_axi_bvalid_out <= 1'b1;
        if (aw_addr_q == skr_pkg::OFF_CTRL || aw_addr_q == skr_pkg::OFF_IRQ_MASK) begin
          s_axi_bresp_out <= skr_pkg::RESP_OKAY;
        end else if (aw_addr_q == skr_pkg::OFF_STATUS ||
                     aw_addr_q == skr_pkg::OFF_DATA ||
                     aw_addr_q == skr_pkg::OFF_IRQ_STAT) begin
          s_axi_bresp_out <= skr_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp_out <= skr_pkg::RESP_SLVERR;
        end
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  assign wr_en = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;

  // Control and mask registers; only byte lane 0 carries fields.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ctrl_q     <= skr_pkg::CTRL_RST;
      irq_mask_q <= skr_pkg::IRQ_RST;
    end else if (wr_en && w_lane0_q) begin
      if (aw_addr_q == skr_pkg::OFF_CTRL) begin
        ctrl_q <= w_data_q[skr_pkg::CTRL_W-1:0];
      end else if (aw_addr_q == skr_pkg::OFF_IRQ_MASK) begin
        irq_mask_q <= w_data_q[skr_pkg::IRQ_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Register bus: read channel
  // ****************************************************************
  assign rd_en = s_axi_arvalid_in && s_axi_arready_out;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= skr_pkg::RESP_OKAY;
    end else if (rd_en) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rresp_out   <= skr_pkg::RESP_OKAY;
      if (s_axi_araddr_in == skr_pkg::OFF_CTRL) begin
        s_axi_rdata_out <= {29'h0, ctrl_q};
      end else if (s_axi_araddr_in == skr_pkg::OFF_STATUS) begin
        s_axi_rdata_out <= {26'h0, skip_line_in, read_latch_q, reader_advance_q,
                            last_unit_q, char_ready_flag_q, rx_active_q};
      end else if (s_axi_araddr_in == skr_pkg::OFF_DATA) begin
        s_axi_rdata_out <= {24'h0, rx_shift_reg_q};
      end else if (s_axi_araddr_in == skr_pkg::OFF_IRQ_STAT) begin
        s_axi_rdata_out <= {30'h0, irq_stat_q};
      end else if (s_axi_araddr_in == skr_pkg::OFF_IRQ_MASK) begin
        s_axi_rdata_out <= {30'h0, irq_mask_q};
      end else begin
        s_axi_rdata_out <= '0;
        s_axi_rresp_out <= skr_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  // Read clears the status, but an event in the same cycle survives.
  assign irq_clr = (rd_en && s_axi_araddr_in == skr_pkg::OFF_IRQ_STAT) ? '1 : '0;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      irq_stat_q <= skr_pkg::IRQ_RST;
      irq_out    <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | {false_start, last_shift};
      irq_out    <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  a_start_on_space: assert property (
    $rose(rx_active_q) |-> $past(!serial_line_in) && $past(cpu_tick))
    else $error("receive started without a start space on a tick");

  a_init_fills_ones: assert property (
    $rose(rx_active_q) |-> reg_all_ones && !last_unit_q)
    else $error("register not initialised on activation");

  a_shift_loads_msb: assert property (
    rx_shift_pulse |=> rx_shift_reg_q[7] == $past(serial_line_in) &&
      rx_shift_reg_q[6:0] == $past(rx_shift_reg_q[7:1]))
    else $error("shift did not load serial level into msb");

  a_ninth_sets_flags: assert property (
    last_shift |=> char_ready_flag_q && last_unit_q)
    else $error("final shift did not set both flags");

  a_last_ends_rx: assert property (
    rx_bit_clock && last_unit_q |-> !rx_shift_pulse ##1 !rx_active_q)
    else $error("tick after last unit did not end reception");

  a_false_start: assert property (
    false_start |-> !rx_shift_pulse ##1 (!rx_active_q && irq_stat_q[1]))
    else $error("false start not rejected");

  a_shift_stops_rdr: assert property (
    rx_shift_pulse && !step_cmd |=> !reader_advance_q)
    else $error("reader advance survived a shift pulse");

  a_skip_pulls_line: assert property (
    skip_cmd && char_ready_flag_q |=> !skip_line_oe_n_out && !skip_line_out)
    else $error("skip line not pulled with flag set");

  a_read_clears_flag: assert property (
    read_cmd && !last_shift |=> !char_ready_flag_q && read_latch_q)
    else $error("read did not clear flag and set latch");

  a_bus_data_valid: assert property (
    read_latch_q |=> read_request_out &&
      io_data_out[7:0] == $past(rx_shift_reg_q))
    else $error("read data not on io bus");

  a_irq_follows_flag: assert property (
    char_ready_flag_q |=> interrupt_request_out)
    else $error("interrupt request missing for character flag");

endmodule // skr_receiver

// ---- pkg/skr_bitclk_if.sv ----
// Control and tick link between the receiver and its bit clock.
interface skr_bitclk_if;
  logic run;
  logic tick;
  modport ctrl (output run, input tick);
  modport gen (input run, output tick);
endinterface : skr_bitclk_if

// ---- pkg/skr_pkg.sv ----
// Shared constants for the serial keyboard receiver.
package skr_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned CPU_CLK_NS      = 1500;
  localparam int unsigned FIRST_DELAY_NS  = 4540000;
  localparam int unsigned UNIT_NS         = 9090000;
  localparam int unsigned CPU_TICK_CYC    = CPU_CLK_NS / CLK_PERIOD_NS;
  localparam int unsigned FIRST_DELAY_CYC = FIRST_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned UNIT_CYC        = UNIT_NS / CLK_PERIOD_NS;
  localparam int          CNT_W           = 20;
  localparam int          CPU_CNT_W       = 8;
  localparam logic [CNT_W-1:0] FIRST_DELAY_CNT = CNT_W'(FIRST_DELAY_CYC);
  localparam logic [CNT_W-1:0] UNIT_CNT        = CNT_W'(UNIT_CYC);
  localparam logic [CPU_CNT_W-1:0] CPU_TICK_LAST = CPU_CNT_W'(CPU_TICK_CYC - 1);

  // ****************************************************************
  // Character and I/O bus
  // ****************************************************************
  localparam int         CHAR_W     = 8;
  localparam int         IO_W       = 18;
  localparam logic [7:0] SHIFT_INIT = 8'hff;
  localparam logic [5:0] IOT_OPCODE = 6'h38;
  localparam logic [5:0] DEV_CODE   = 6'h03;
  localparam int         OPC_HI     = 17;
  localparam int         OPC_LO     = 12;
  localparam int         SEL_HI     = 11;
  localparam int         SEL_LO     = 6;
  localparam int         BIT_MB17   = 0;
  localparam int         BIT_MB16   = 1;
  localparam int         BIT_MB13   = 4;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int         ADDR_W       = 8;
  localparam int         DATA_W       = 32;
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_DATA     = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam int         CTRL_W       = 3;
  localparam int         CTRL_IE      = 0;
  localparam int         CTRL_DUPLEX  = 1;
  localparam int         CTRL_ECHO    = 2;
  localparam logic [2:0] CTRL_RST     = 3'h0;
  localparam int         IRQ_W        = 2;
  localparam logic [1:0] IRQ_RST      = 2'h0;

endpackage : skr_pkg
